// ### logic/dcei_chan_irq.sv
// Per-channel enable and status registers, event flags and interrupt lines.
// Assumes event inputs and I/O requests are synchronous one-cycle pulses.
`timescale 1ns/10ps
`include "dcei_regs.svh"

// What this block does
// - Enable bits 15-6 read zero, unwritable
// - Block done sets flag, raises channel irq
// - Last frame start sets flag, raises irq
// - Frame done sets flag, raises irq
// - Half frame moved sets flag, raises irq
// - Odd frames: half when moved exceeds remaining
// - Sync again before service is drop
// - Enabled drop sets flag, raises irq
// - Timeout sets flag, raises bus-error irq
// - Disabled events set nothing, raise nothing
// - Reset enables 000011, status all zero
// - Status read returns flags then clears
// - Sync status bit set by sync, cleared by service or status read
// - Own irq line per channel, shared bus-error
module dcei_chan_irq #(
    parameter int NCH = 6,     // Number of channels
    parameter int CNT_W = 16   // Width of element count within a frame
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESETN,
    // Register I/O port
    input wire dcei_pkg::dcei_io_t IO_REQ,
    output logic [15:0] IO_RDATA,
    // Channel engine events and frame length
    input wire dcei_pkg::dcei_evt_t [NCH-1:0] EVT,
    input wire logic [NCH-1:0][CNT_W-1:0] FRAME_LEN,
    // Interrupt requests to the processor core
    output logic [NCH-1:0] CH_IRQ,
    output logic BUS_ERR_IRQ
);

    // Refuse sizes the logic cannot serve, at elaboration rather than at run time
    // The channel select is three bits wide, so at most eight channels fit
    if (NCH < 1 || NCH > 8)
    begin : g_bad_nch
        $error("NCH must be 1 to 8");
    end
    // The doubled moved count needs one spare bit beside the frame length
    if (CNT_W < 2 || CNT_W > 30)
    begin : g_bad_cnt
        $error("CNT_W must be 2 to 30");
    end

    logic [NCH-1:0][5:0] en_q;      // Enable fields
    logic [NCH-1:0][5:0] en_d;
    logic [NCH-1:0][5:0] flag_q;    // Status flags 5..0
    logic [NCH-1:0][5:0] flag_d;
    logic [NCH-1:0] pend_q;         // Sync request pending
    logic [NCH-1:0] pend_d;
    logic [NCH-1:0] sync_seen_q;    // Visible sync bit, cleared by a status read
    logic [NCH-1:0] sync_seen_d;
    logic [NCH-1:0][CNT_W-1:0] moved_q; // Elements moved in frame
    logic [NCH-1:0][CNT_W-1:0] moved_d;
    logic [NCH-1:0] half_seen_q;    // Half event already given this frame
    logic [NCH-1:0] half_seen_d;
    logic [NCH-1:0] irq_q;          // Channel irq pulses
    logic [NCH-1:0] irq_d;
    logic [NCH-1:0] to_hit;         // Enabled timeouts this cycle
    logic bus_q;                    // Bus-error irq pulse
    logic bus_d;
    logic [15:0] rdata_q;           // Read data
    logic [15:0] rdata_d;

    // Per-channel event logic, one copy per channel
    // Each channel keeps its own element counter so channels never wait on one
    // another; the cost is a counter per channel even when half events stay off
    for (genvar c = 0; c < NCH; c++)
    begin : g_ch
        logic hit_io;               // I/O request addresses this channel
        logic clr_rd;               // Status read of this channel clears it
        logic [5:0] raw;            // Events this cycle, in flag order
        logic [5:0] set;            // Enabled events
        logic [CNT_W:0] twice;      // Twice the elements moved after this one
        logic half_evt;

        // Decode of this cycle's request and events
        always_comb
        begin
            hit_io = (IO_REQ.chan == 3'(c));
            clr_rd = hit_io && IO_REQ.rd && (IO_REQ.sel == `DCEI_SEL_STATUS);
            // Twice the new moved count reaching the length means moved >= remaining
            twice = {moved_q[c] + CNT_W'(1), 1'b0};
            half_evt = EVT[c].elem_done && !half_seen_q[c] && !EVT[c].frame_done
                && (FRAME_LEN[c] != '0)
                && (twice >= {1'b0, FRAME_LEN[c]});
            raw[`DCEI_BIT_BLOCK] = EVT[c].block_done;
            raw[`DCEI_BIT_LAST] = EVT[c].last_start;
            raw[`DCEI_BIT_FRAME] = EVT[c].frame_done;
            raw[`DCEI_BIT_HALF] = half_evt;
            raw[`DCEI_BIT_DROP] = EVT[c].sync_evt && pend_q[c];
            raw[`DCEI_BIT_TIMEOUT] = EVT[c].timeout;
            set = raw & en_q[c];
        end

        // Enable group: software writes land in the low six bits only
        always_comb
        begin
            // Enable register write keeps only the low six bits
            en_d[c] = en_q[c];
            if (hit_io && IO_REQ.wr && IO_REQ.sel == `DCEI_SEL_ENABLE)
            begin
                en_d[c] = IO_REQ.wdata[5:0];
            end
        end

        // Flag group: sticky until a status read of this channel
        always_comb
        begin
            // Read clears, but an event in the same cycle wins
            flag_d[c] = flag_q[c];
            if (clr_rd)
            begin
                flag_d[c] = '0;
            end
            flag_d[c] = flag_d[c] | set;
        end

        // Sync group: the pending state stays hidden from reads, so that a
        // status read cannot mask a drop that is still to come
        always_comb
        begin
            // Sync pending: a new event while pending still leaves it pending
            pend_d[c] = pend_q[c];
            if (EVT[c].sync_evt)
            begin
                pend_d[c] = 1'b1;
            end
            else if (EVT[c].sync_done)
            begin
                pend_d[c] = 1'b0;
            end
            // Visible sync bit: a status read clears it, a new event sets it again
            sync_seen_d[c] = sync_seen_q[c];
            if (clr_rd || EVT[c].sync_done)
            begin
                sync_seen_d[c] = 1'b0;
            end
            if (EVT[c].sync_evt)
            begin
                sync_seen_d[c] = 1'b1;
            end
        end

        // Frame group: element count and the once-per-frame half marker
        always_comb
        begin
            // Element counting restarts at each frame boundary
            moved_d[c] = moved_q[c];
            half_seen_d[c] = half_seen_q[c] | half_evt;
            if (EVT[c].frame_done)
            begin
                moved_d[c] = '0;
                half_seen_d[c] = 1'b0;
            end
            else if (EVT[c].elem_done)
            begin
                moved_d[c] = moved_q[c] + CNT_W'(1);
            end
        end

        // Interrupt group: one pulse per cycle with any enabled event
        always_comb
        begin
            // Timeout goes to the shared line, everything else to the channel line
            irq_d[c] = |set[5:1];
            to_hit[c] = set[`DCEI_BIT_TIMEOUT];
        end
    end

    // Shared bus-error line: any channel's enabled timeout raises it
    always_comb
    begin
        bus_d = |to_hit;
    end

    // Register read mux; the answer holds until the next read
    always_comb
    begin
        rdata_d = rdata_q;
        if (IO_REQ.rd)
        begin
            rdata_d = 16'h0000;
            if (int'(IO_REQ.chan) >= NCH)
            begin
                // Missing channel reads as zero
                rdata_d = 16'h0000;
            end
            else if (IO_REQ.sel == `DCEI_SEL_ENABLE)
            begin
                rdata_d = {10'h000, en_q[IO_REQ.chan]};
            end
            else
            begin
                rdata_d = {9'h000, sync_seen_q[IO_REQ.chan], flag_q[IO_REQ.chan]};
            end
        end
    end

    // Enable registers; reset leaves drop and timeout armed
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
        begin
            for (int c = 0; c < NCH; c++)
            begin
                en_q[c] <= `DCEI_ENABLE_RESET;
            end
        end
        else
        begin
            en_q <= en_d;
        end
    end

    // Status flags; all clear after reset
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
        begin
            flag_q <= '0;
        end
        else
        begin
            flag_q <= flag_d;
        end
    end

    // Sync tracking: hidden pending state and the visible sync bit
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
        begin
            pend_q <= '0;
            sync_seen_q <= '0;
        end
        else
        begin
            pend_q <= pend_d;
            sync_seen_q <= sync_seen_d;
        end
    end

    // Frame position; a reset mid-frame starts counting from zero
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
        begin
            moved_q <= '0;
            half_seen_q <= '0;
        end
        else
        begin
            moved_q <= moved_d;
            half_seen_q <= half_seen_d;
        end
    end

    // Channel interrupt pulses, registered so the core sees clean edges
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
        begin
            irq_q <= '0;
        end
        else
        begin
            irq_q <= irq_d;
        end
    end

    // Shared bus-error pulse
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
        begin
            bus_q <= 1'b0;
        end
        else
        begin
            bus_q <= bus_d;
        end
    end

    // Read data register
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
        begin
            rdata_q <= 16'h0000;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    assign CH_IRQ = irq_q;
    assign BUS_ERR_IRQ = bus_q;
    assign IO_RDATA = rdata_q;

endmodule

// ### logic/dcei_regs.svh
// Register layout constants for the per-channel event and interrupt block.
// Assumes a 16-bit I/O data path; included by its bare name.
`ifndef DCEI_REGS_SVH
`define DCEI_REGS_SVH

// Register select on the I/O port (one enable and one status per channel)
`define DCEI_SEL_ENABLE 1'h0
`define DCEI_SEL_STATUS 1'h1

// Bit positions shared by enable and status registers, except sync (status only)
`define DCEI_BIT_TIMEOUT 0
`define DCEI_BIT_DROP 1
`define DCEI_BIT_HALF 2
`define DCEI_BIT_FRAME 3
`define DCEI_BIT_LAST 4
`define DCEI_BIT_BLOCK 5
`define DCEI_BIT_SYNC 6

// Reset value of the enable field: drop and timeout enabled
`define DCEI_ENABLE_RESET 6'h03
// Mask of writable enable bits
`define DCEI_ENABLE_MASK 16'h003F

`endif

// ### logic/dcei_pkg.sv
// Types shared by the channel event and interrupt block.
// Assumes nothing beyond a SystemVerilog compiler.
package dcei_pkg;

    // Transfer events reported by the channel engine, one-cycle pulses
    typedef struct packed {
        logic block_done;   // Whole block moved
        logic last_start;   // Final frame begins moving
        logic frame_done;   // Whole frame moved
        logic elem_done;    // One element moved
        logic sync_evt;     // Synchronization event arrived
        logic sync_done;    // Request from last sync event serviced
        logic timeout;      // Timeout at source or destination port
    } dcei_evt_t;

    // Register I/O request
    typedef struct packed {
        logic [2:0] chan;   // Channel number
        logic sel;          // Enable or status register
        logic wr;           // Write strobe
        logic rd;           // Read strobe
        logic [15:0] wdata; // Write data
    } dcei_io_t;

endpackage

// ### dv/dcei_chk.sv
// Assertions on the channel event block, watching channel 0 and the error line.
// Assumes it is bound into dcei_chan_irq and its reset is synchronous.
`timescale 1ns/10ps
module dcei_chk #(
    parameter int NCH = 6 // Channel count
) (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire dcei_pkg::dcei_io_t IO_REQ,
    input wire logic [15:0] IO_RDATA,
    input wire dcei_pkg::dcei_evt_t [NCH-1:0] EVT,
    input wire logic [NCH-1:0] CH_IRQ,
    input wire logic BUS_ERR_IRQ
);
    logic [5:0] en_q; // Shadow of channel 0 enables, gates the event checks
    logic rd0_s; // Quiet status read of channel 0
    assign rd0_s = IO_REQ.rd && IO_REQ.sel && IO_REQ.chan == 3'h0 && EVT[0] == 7'h00;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);
    // Shadow follows enable writes; upper bits are never stored
    always_ff @(posedge SYS_CLK)
        en_q <= !RESETN ? 6'h03 :
            (IO_REQ.wr && !IO_REQ.sel && IO_REQ.chan == 3'h0) ? IO_REQ.wdata[5:0] : en_q;
    rst_quiet_a: assert property (disable iff (1'b0) !RESETN |=>
        CH_IRQ == '0 && !BUS_ERR_IRQ && IO_RDATA == 16'h0000) else $error("not idle in reset");
    en_read_a: assert property (IO_REQ.rd && !IO_REQ.wr && !IO_REQ.sel && IO_REQ.chan == 3'h0
        |=> IO_RDATA == {10'h000, $past(en_q)}) else $error("enable readback");
    block_irq_a: assert property (EVT[0].block_done && en_q[5] |=> CH_IRQ[0])
        else $error("block irq missing");
    frame_irq_a: assert property (EVT[0].frame_done && en_q[3] |=> CH_IRQ[0])
        else $error("frame irq missing");
    tmo_err_a: assert property (EVT[0].timeout && en_q[0] |=> BUS_ERR_IRQ)
        else $error("bus error irq missing");
    tmo_only_a: assert property (EVT[0] == 7'h01 |=> !CH_IRQ[0])
        else $error("timeout on channel line");
    masked_quiet_a: assert property (EVT[0] == 7'h40 && !en_q[5] |=> !CH_IRQ[0])
        else $error("masked event raised irq");
    clear_read_a: assert property (rd0_s [*2] |=> IO_RDATA[6:0] == 7'h00)
        else $error("flags kept after read");
    cover property (CH_IRQ[0]);
    cover property (BUS_ERR_IRQ);
    cover property (rd0_s ##1 IO_RDATA[2]);
endmodule
bind dcei_chan_irq dcei_chk #(.NCH(NCH)) u_chk (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
    .IO_REQ(IO_REQ), .IO_RDATA(IO_RDATA), .EVT(EVT), .CH_IRQ(CH_IRQ), .BUS_ERR_IRQ(BUS_ERR_IRQ));

// ### dv/dcei_core_model.sv
// Core side model: counts channel and bus-error interrupt pulses.
// Assumes pulses are one cycle wide on the rising edge.
`timescale 1ns/10ps
module dcei_core_model #(
    parameter int NCH = 6
) (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic [NCH-1:0] CH_IRQ, // One line per channel
    input wire logic BUS_ERR_IRQ, // Shared error line
    output int ch_cnt [NCH],
    output int bus_cnt
);
    // Pulse counting, so a stuck line shows as too many requests
    always @(posedge SYS_CLK)
    begin
        for (int i = 0; i < NCH; i++)
            ch_cnt[i] <= !RESETN ? 0 : ch_cnt[i] + int'(CH_IRQ[i] === 1'b1);
        bus_cnt <= !RESETN ? 0 : bus_cnt + int'(BUS_ERR_IRQ === 1'b1);
    end
endmodule

// ### dv/tb_top.sv
// Self-checking bench for the channel event and interrupt block.
// Assumes the bound checker and the core model beside the design.
`timescale 1ns/10ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin errors++; \
    $display("wrong value %s exp %0h got %0h", n, e, s); end end
module tb_top;
    localparam int NCH = 6;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    dcei_pkg::dcei_io_t io = '0;
    dcei_pkg::dcei_evt_t [NCH-1:0] evt = '0;
    logic [NCH-1:0][15:0] flen = '0; // Frame lengths
    logic [15:0] rdata, d, nxt;
    logic [NCH-1:0] ch_irq;
    logic bus_irq;
    logic rd_seen = 1'b0;
    logic [15:0] exp_q [$]; // Expected read answers, oldest first
    int ch_cnt [NCH];
    int bus_cnt;
    int exp_ch [NCH] = '{default: 0};
    int errors = 0;
    int samples_checked = 0;
    int seed = 78811;
    always #2.5 sys_clk = ~sys_clk;
    dcei_chan_irq #(.NCH(NCH), .CNT_W(16)) DUT (.SYS_CLK(sys_clk), .RESETN(resetn), .IO_REQ(io),
        .IO_RDATA(rdata), .EVT(evt), .FRAME_LEN(flen), .CH_IRQ(ch_irq), .BUS_ERR_IRQ(bus_irq));
    dcei_core_model #(.NCH(NCH)) core (.SYS_CLK(sys_clk), .RESETN(resetn), .CH_IRQ(ch_irq),
        .BUS_ERR_IRQ(bus_irq), .ch_cnt(ch_cnt), .bus_cnt(bus_cnt));
    // One cycle of requests and events; every call replaces the last
    task automatic step(int c, logic s, logic w, logic r, logic [15:0] wd, logic [6:0] m);
        @(posedge sys_clk);
        #1;
        io = '{c[2:0], s, w, r, wd};
        evt = '0;
        evt[c] = m;
    endtask
    task automatic rd(int c, logic s, logic [15:0] e);
        step(c, s, 1'b0, 1'b1, 16'h0000, 7'h00);
        exp_q.push_back(e);
    endtask
    // Answers come one cycle after the read
    always @(posedge sys_clk)
    begin
        if (rd_seen)
        begin
            nxt = exp_q.pop_front();
            `CHK("read data", nxt, rdata)
        end
        rd_seen <= io.rd;
    end
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        for (int c = 0; c < NCH; c++)
        begin
            rd(c, 1'b0, 16'h0003);
            rd(c, 1'b1, 16'h0000);
            d = 16'($random(seed));
            step(c, 1'b0, 1'b1, 1'b0, d, 7'h00);
            rd(c, 1'b0, d & 16'h003F);
            step(c, 1'b1, 1'b1, 1'b0, 16'hFFFF, 7'h00);
            step(c, 1'b0, 1'b1, 1'b0, 16'hFFFF, 7'h00);
            rd(c, 1'b1, 16'h0000);
        end
        rd(NCH, 1'b0, 16'h0000);
        $display("register test done");
        // Timeout, frame, last then block; flags hold until read
        for (int c = 0; c < NCH; c++)
        begin
            foreach (d[i]) if (i < 4) step(c, 1'b0, 1'b0, 1'b0, 16'h0000, 7'h40 >> i * (1 + i / 3));
            rd(c, 1'b1, 16'h0039);
            rd(c, 1'b1, 16'h0000);
            exp_ch[c] += 3;
        end
        $display("event test done");
        // Odd frame fires on the third element, even on the second
        flen[0] = 16'h0005;
        repeat (2) step(0, 1'b0, 1'b0, 1'b0, 16'h0000, 7'h08);
        rd(0, 1'b1, 16'h0000);
        step(0, 1'b0, 1'b0, 1'b0, 16'h0000, 7'h08);
        rd(0, 1'b1, 16'h0004);
        flen[0] = 16'h0004;
        step(0, 1'b0, 1'b0, 1'b0, 16'h0000, 7'h10);
        repeat (2) step(0, 1'b0, 1'b0, 1'b0, 16'h0000, 7'h08);
        rd(0, 1'b1, 16'h000C);
        $display("half test done");
        // Second sync before service is a drop, even after a read hid the sync bit
        step(0, 1'b0, 1'b0, 1'b0, 16'h0000, 7'h04);
        rd(0, 1'b1, 16'h0040);
        rd(0, 1'b1, 16'h0000);
        step(0, 1'b0, 1'b0, 1'b0, 16'h0000, 7'h04);
        rd(0, 1'b1, 16'h0042);
        step(0, 1'b0, 1'b0, 1'b0, 16'h0000, 7'h02);
        rd(0, 1'b1, 16'h0000);
        exp_ch[0] += 4;
        $display("drop test done");
        // All enables off: only the sync bit recorded, nothing raised
        step(0, 1'b0, 1'b1, 1'b0, 16'h0000, 7'h00);
        step(0, 1'b0, 1'b0, 1'b0, 16'h0000, 7'h40);
        step(0, 1'b0, 1'b0, 1'b0, 16'h0000, 7'h35);
        step(0, 1'b0, 1'b0, 1'b0, 16'h0000, 7'h04);
        rd(0, 1'b1, 16'h0040);
        repeat (3) step(0, 1'b0, 1'b0, 1'b0, 16'h0000, 7'h00);
        for (int c = 0; c < NCH; c++)
            `CHK("channel irq count", exp_ch[c], ch_cnt[c])
        `CHK("bus error count", NCH, bus_cnt)
        $display("mask test done");
        stop_test;
    end
    // Run takes about 110 cycles
    initial
    begin
        #10000;
        errors++;
        stop_test;
    end
endmodule
